//--- pkg/bcro_pkg.sv
/*
  Shared constants and types for board control register one: offset, field
  layout, power-on defaults, supply encodings and the bus and board carriers.
  Assumes a 32-bit local bus whose board register space is reached by byte offset.
*/
package bcro_pkg;

  localparam int unsigned BCRO_ADDR_W = 5;
  localparam int unsigned BCRO_DATA_W = 32;
  localparam int unsigned BCRO_REG_W  = 16;

  localparam logic [BCRO_ADDR_W-1:0] BCRO_OFFSET = 5'h04;

  localparam int unsigned BCRO_BIT_LOCK    = 5;
  localparam int unsigned BCRO_BIT_VISIBLE = 6;

  // Bit 5 and bit 6 are steered by the lock logic, not by the plain write
  localparam logic [BCRO_REG_W-1:0] BCRO_PLAIN_WMASK = 16'hFF9F;
  localparam logic [BCRO_REG_W-1:0] BCRO_RESET       = 16'h7D1C;
  localparam logic [15:0]           BCRO_UPPER_ZERO  = 16'h0000;

  // Field order follows bit order, bit 15 first
  typedef struct packed {
    logic       card_supply_sel1;
    logic       sync_dram_active;
    logic       serial_port2_xcvr_on_n;
    logic       narrow_dram_n;
    logic [1:0] card_prog_supply_sel;
    logic       card_supply_sel0;
    logic       card_slot_on_n;
    logic       serial_port1_xcvr_on_n;
    logic       board_regs_visible_n;
    logic       visibility_lock_n;
    logic       flash_boot_cfg_n;
    logic       infrared_on_n;
    logic       ether_xcvr_on_n;
    logic       dram_map_select_n;
    logic       flash_map_select_n;
  } bcro_ctl_t;

  typedef enum logic [1:0] {BCRO_VCC_0V, BCRO_VCC_5V, BCRO_VCC_3V3} bcro_vcc_t;
  typedef enum logic [1:0] {BCRO_VPP_0V, BCRO_VPP_5V, BCRO_VPP_12V, BCRO_VPP_HIZ} bcro_vpp_t;

  typedef struct packed {
    logic      flash_mapped;
    logic      cs0_offboard;
    logic      dram_mapped;
    logic      cs23_offboard;
    logic      ether_enable;
    logic      ether_standby;
    logic      ir_enable;
    logic      ir_shutdown;
    logic      cfg_from_flash;
    logic      regs_visible;
    logic      cs1_offboard;
    logic      serial1_enable;
    logic      serial2_enable;
    logic      card_buf_enable;
    bcro_vcc_t card_vcc;
    bcro_vpp_t card_vpp;
    logic      dram_16bit;
    logic      sdram_mapped;
    logic      sdram_lowpower;
  } bcro_board_t;

  localparam bcro_board_t BCRO_BOARD_RESET = '{
    flash_mapped: 1'b1, cs0_offboard: 1'b0, dram_mapped: 1'b1, cs23_offboard: 1'b0,
    ether_enable: 1'b0, ether_standby: 1'b1, ir_enable: 1'b0, ir_shutdown: 1'b1,
    cfg_from_flash: 1'b0, regs_visible: 1'b1, cs1_offboard: 1'b0,
    serial1_enable: 1'b1, serial2_enable: 1'b0, card_buf_enable: 1'b0,
    card_vcc: BCRO_VCC_0V, card_vpp: BCRO_VPP_HIZ, dram_16bit: 1'b0,
    sdram_mapped: 1'b1, sdram_lowpower: 1'b0};

  typedef struct packed {
    logic                   strobe;
    logic                   write;
    logic [BCRO_ADDR_W-1:0] addr;
    logic [BCRO_DATA_W-1:0] wdata;
  } bcro_bus_req_t;

  typedef struct packed {
    logic                   ack;
    logic                   oe;
    logic [BCRO_DATA_W-1:0] rdata;
  } bcro_bus_rsp_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } bcro_sync_t;

endpackage

//--- design/bcro_sync3.sv
/*
  Three-stage synchroniser for a level from outside the clock domain.
  Assumes the source is a slow level; the output moves once stages two and three agree.
*/
`timescale 1ns/1ns
module bcro_sync3 import bcro_pkg::*; #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      level_out
);

  bcro_sync_t state_reg;
  bcro_sync_t state_next;

  always_comb begin
    state_next    = state_reg;
    state_next.s1 = async_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.s2 == state_reg.s3) begin
      state_next.level = state_reg.s3;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL, level: RESET_LEVEL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.level;

endmodule

//--- design/bcro_supply_decode.sv
/*
  Card supply decoder: turns the VCC select pair and the programming supply
  field into supply levels. Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns
module bcro_supply_decode import bcro_pkg::*; (
  input  wire logic       sel0,
  input  wire logic       sel1,
  input  wire logic [1:0] prog_sel,
  output bcro_vcc_t       vcc,
  output bcro_vpp_t       vpp
);

  logic [1:0] vcc_code;
  logic [1:0] vpp_code;

  // Select 0 is the leading digit of each code
  assign vcc_code = {sel0, sel1};
  assign vpp_code = {prog_sel[0], prog_sel[1]};

  always_comb begin
    unique case (vcc_code)
      2'h0: vcc = BCRO_VCC_0V;
      2'h1: vcc = BCRO_VCC_5V;
      2'h2: vcc = BCRO_VCC_3V3;
      2'h3: vcc = BCRO_VCC_0V;
    endcase
  end

  always_comb begin
    unique case (vpp_code)
      2'h0: vpp = BCRO_VPP_0V;
      2'h1: vpp = BCRO_VPP_5V;
      2'h2: vpp = BCRO_VPP_12V;
      2'h3: vpp = BCRO_VPP_HIZ;
    endcase
  end

endmodule

//--- design/bcro_top.sv
/*
  Board control register one: a 16-bit control word in a 32-bit slot of the
  board register space, its write protection for the visibility bit, the
  hard-reset configuration drive and the decoded board enables.
  Assumes a local bus synchronous to clk_sys, a one-cycle unlock pulse from the
  fourth board register, and an asynchronous hard-reset pin.
*/
//
// Contract
// - Register answers at byte offset 4 of the board register space.
// - Power-on reset loads every field with its default.
// - Control bits are driven out to the connectors.
// - Bit 0 low maps flash; high frees chip select 0.
// - Bit 1 low maps DRAM; high frees chip selects 2 and 3.
// - Bit 2 low enables ethernet transceiver; high puts it in standby.
// - Bit 3 low enables infrared; high shuts it down, frees channel 2.
// - Bit 4 low stops driving reset configuration word during hard reset.
// - Bit 5 is read-only lock; locked blocks bit 6; any write relocks; a write with an unlock pulse in the same cycle leaves it unlocked.
// - Bit 6 high hides all board registers and frees chip select 1.
// - Writing 1 to bit 6 is taken only while unlocked.
// - After hiding, last values keep configuring the board through hard reset.
// - Bit 7 low enables serial port 1; high puts it in standby.
// - Bit 8 low enables card buffers; high disables them all.
// - Bits 9 and 15 select card VCC: 0, 5, 3.3, 0 volts.
// - Bits 10 to 11 select card VPP: 0, 5, 12 volts, high impedance.
// - Bit 12 low makes DRAM 16 bits wide, else 32.
// - Bit 13 low enables serial port 2; high puts it in standby.
// - Bit 14 high maps SDRAM; low puts it in low power, unmapped.
// - Visibility bit comes up low at power-up.
`timescale 1ns/1ns
module bcro_top import bcro_pkg::*; (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  bus_cs_n,
  input  wire bcro_bus_req_t         bus_req,
  input  wire logic                  unlock_pulse,
  input  wire logic                  hard_reset_pin_n,
  input  wire logic [BCRO_REG_W-1:0] reset_cfg_word,
  output bcro_bus_rsp_t              bus_rsp,
  output bcro_ctl_t                  ctl_out,
  output bcro_board_t                board_out,
  output logic                       cfg_drive
);

  typedef struct packed {
    bcro_ctl_t     ctl;
    bcro_board_t   board;
    bcro_bus_rsp_t rsp;
    logic          cfg_drive;
  } bcro_state_t;

  bcro_state_t state_reg;
  bcro_state_t state_next;

  logic                  hard_reset_n;
  logic                  in_hard_reset;
  logic                  addr_hit;
  logic                  access;
  logic                  wr_access;
  logic                  rd_access;
  logic [BCRO_REG_W-1:0] wr_word;
  logic [BCRO_REG_W-1:0] merged_word;
  bcro_ctl_t             ctl_new;
  bcro_vcc_t             vcc_level;
  bcro_vpp_t             vpp_level;

  // Hard reset arrives from a pin; it is idle high at power-up
  bcro_sync3 #(
    .RESET_LEVEL (1'b1)
  ) u_hreset_sync (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .async_in  (hard_reset_pin_n),
    .level_out (hard_reset_n)
  );

  assign in_hard_reset = ~hard_reset_n;

  // Only the offset of this register is decoded; the other offsets of the
  // space belong to neighbouring registers and get no answer from here
  assign addr_hit = bus_req.addr == BCRO_OFFSET;

  // A hidden register space answers nothing at all, read or write
  assign access = bus_req.strobe & ~bus_cs_n & addr_hit
                & ~state_reg.ctl.board_regs_visible_n
                & ~in_hard_reset;

  assign wr_access = access & bus_req.write;
  assign rd_access = access & ~bus_req.write;

  // Upper half of the bus is dropped on writes
  assign wr_word = bus_req.wdata[BCRO_REG_W-1:0];

  // Plain fields take the written value; lock and visibility are handled below
  assign merged_word = (wr_word & BCRO_PLAIN_WMASK)
                     | (state_reg.ctl & ~BCRO_PLAIN_WMASK);

  // An unlock alone must not pick up whatever the idle bus happens to carry
  always_comb begin
    ctl_new = state_reg.ctl;
    if (wr_access) begin
      ctl_new = bcro_ctl_t'(merged_word);
      // Visibility moves only while unlocked, otherwise the written bit 6 is ignored
      if (state_reg.ctl.visibility_lock_n) begin
        ctl_new.board_regs_visible_n = wr_word[BCRO_BIT_VISIBLE];
      end
      // Every write spends the single unlock
      ctl_new.visibility_lock_n = 1'b0;
    end
    // An unlock in the same cycle as a write wins, so it is not lost
    if (unlock_pulse) begin
      ctl_new.visibility_lock_n = 1'b1;
    end
  end

  // Supply codes
  bcro_supply_decode u_supply (
    .sel0     (ctl_new.card_supply_sel0),
    .sel1     (ctl_new.card_supply_sel1),
    .prog_sel (ctl_new.card_prog_supply_sel),
    .vcc      (vcc_level),
    .vpp      (vpp_level)
  );

  always_comb begin
    state_next = state_reg;

    // Control word
    if (wr_access || unlock_pulse) begin
      state_next.ctl = ctl_new;
    end

    // Bus answer
    state_next.rsp.ack   = access;
    state_next.rsp.oe    = rd_access;
    state_next.rsp.rdata = '0;
    if (rd_access) begin
      state_next.rsp.rdata = {BCRO_UPPER_ZERO, state_reg.ctl};
    end

    // Configuration word is placed on the bus for the whole hard reset unless
    // flash supplies it; the bus carries no other traffic then
    state_next.cfg_drive = in_hard_reset & state_reg.ctl.flash_boot_cfg_n;
    if (state_next.cfg_drive) begin
      state_next.rsp.oe    = 1'b1;
      state_next.rsp.rdata = {BCRO_UPPER_ZERO, reset_cfg_word};
    end

    // Board enables follow the word that is about to be held; hard reset does
    // not touch them, only power-on does
    state_next.board.flash_mapped    = ~state_next.ctl.flash_map_select_n;
    state_next.board.cs0_offboard    = state_next.ctl.flash_map_select_n;
    state_next.board.dram_mapped     = ~state_next.ctl.dram_map_select_n;
    state_next.board.cs23_offboard   = state_next.ctl.dram_map_select_n;
    state_next.board.ether_enable    = ~state_next.ctl.ether_xcvr_on_n;
    state_next.board.ether_standby   = state_next.ctl.ether_xcvr_on_n;
    state_next.board.ir_enable       = ~state_next.ctl.infrared_on_n;
    state_next.board.ir_shutdown     = state_next.ctl.infrared_on_n;
    state_next.board.cfg_from_flash  = ~state_next.ctl.flash_boot_cfg_n;
    state_next.board.regs_visible    = ~state_next.ctl.board_regs_visible_n;
    state_next.board.cs1_offboard    = state_next.ctl.board_regs_visible_n;
    state_next.board.serial1_enable  = ~state_next.ctl.serial_port1_xcvr_on_n;
    state_next.board.serial2_enable  = ~state_next.ctl.serial_port2_xcvr_on_n;
    state_next.board.card_buf_enable = ~state_next.ctl.card_slot_on_n;
    state_next.board.card_vcc        = vcc_level;
    state_next.board.card_vpp        = vpp_level;
    state_next.board.dram_16bit      = ~state_next.ctl.narrow_dram_n;
    state_next.board.sdram_mapped    = state_next.ctl.sync_dram_active;
    state_next.board.sdram_lowpower  = ~state_next.ctl.sync_dram_active;
  end

  // Only power-on reset restores defaults, so a hidden space keeps its
  // settings through any number of hard resets
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.ctl       <= bcro_ctl_t'(BCRO_RESET);
      state_reg.board     <= BCRO_BOARD_RESET;
      state_reg.rsp       <= '0;
      state_reg.cfg_drive <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus_rsp   = state_reg.rsp;
  assign ctl_out   = state_reg.ctl;
  assign board_out = state_reg.board;
  assign cfg_drive = state_reg.cfg_drive;

endmodule

//--- verification/bcro_top_properties.sv
/* Checker for bcro_top: bus answers, lock, hiding, hard-reset drive.
   Sees only the top ports; bound into every bcro_top. */
`timescale 1ns/1ns
module bcro_top_properties import bcro_pkg::*; (
  input wire logic          clk_sys,
  input wire logic          rst_b,
  input wire logic          bus_cs_n,
  input wire bcro_bus_req_t bus_req,
  input wire logic          unlock_pulse,
  input wire logic          hard_reset_pin_n,
  input wire logic [15:0]   reset_cfg_word,
  input wire bcro_bus_rsp_t bus_rsp,
  input wire bcro_ctl_t     ctl_out,
  input wire bcro_board_t   board_out,
  input wire logic          cfg_drive
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Pin must stay high long enough for the synchroniser to clear
  logic [2:0] hi_cnt;
  logic       take;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) hi_cnt <= 3'h7;
    else if (!hard_reset_pin_n) hi_cnt <= 3'h0;
    else if (hi_cnt != 3'h7) hi_cnt <= hi_cnt + 3'h1;
  assign take = bus_req.strobe && !bus_cs_n && bus_req.addr == BCRO_OFFSET
                && !ctl_out.board_regs_visible_n && hi_cnt == 3'h7;
  property p_off; bus_req.strobe && bus_req.addr != BCRO_OFFSET |=> !bus_rsp.ack; endproperty
  a_off: assert property (p_off) else $error("answer at foreign offset");
  property p_rd; take && !bus_req.write |=> bus_rsp.ack && bus_rsp.oe
    && bus_rsp.rdata == {BCRO_UPPER_ZERO, $past(ctl_out)}; endproperty
  a_rd: assert property (p_rd) else $error("bad read answer");
  property p_wr; take && bus_req.write && !unlock_pulse |=> bus_rsp.ack
    && !ctl_out.visibility_lock_n && (({16'h0000, ctl_out} ^ $past(bus_req.wdata))
    & {16'h0000, BCRO_PLAIN_WMASK}) == 32'h0000_0000; endproperty
  a_wr: assert property (p_wr) else $error("bad write result");
  property p_lk; take && bus_req.write && !ctl_out.visibility_lock_n
    |=> !ctl_out.board_regs_visible_n; endproperty
  a_lk: assert property (p_lk) else $error("hidden while locked");
  property p_hide; take && bus_req.write && ctl_out.visibility_lock_n
    && bus_req.wdata[BCRO_BIT_VISIBLE] |=> ctl_out.board_regs_visible_n [*3]; endproperty
  a_hide: assert property (p_hide) else $error("hide not kept");
  property p_ref; bus_req.strobe && (bus_cs_n || ctl_out.board_regs_visible_n)
    && !unlock_pulse |=> !bus_rsp.ack && $stable(ctl_out); endproperty
  a_ref: assert property (p_ref) else $error("refused access acted");
  property p_unl; unlock_pulse |=> ctl_out.visibility_lock_n; endproperty
  a_unl: assert property (p_unl) else $error("unlock lost");
  // An unlock with no write in the same cycle touches only the lock bit
  property p_ukeep; unlock_pulse && !(bus_req.strobe && bus_req.write)
    |=> ((ctl_out ^ $past(ctl_out)) & 16'hFFDF) == 16'h0000; endproperty
  a_ukeep: assert property (p_ukeep) else $error("unlock changed other bits");
  property p_cfg; cfg_drive |-> bus_rsp.oe
    && bus_rsp.rdata == {BCRO_UPPER_ZERO, $past(reset_cfg_word)}; endproperty
  a_cfg: assert property (p_cfg) else $error("config word not driven");
  property p_nocfg; !ctl_out.flash_boot_cfg_n && !$past(ctl_out.flash_boot_cfg_n)
    |-> !cfg_drive; endproperty
  a_nocfg: assert property (p_nocfg) else $error("config driven in flash mode");
  property p_map; board_out.cs1_offboard == ctl_out.board_regs_visible_n
    && board_out.flash_mapped != ctl_out.flash_map_select_n
    && board_out.sdram_mapped == ctl_out.sync_dram_active; endproperty
  a_map: assert property (p_map) else $error("board enables disagree");
endmodule
bind bcro_top bcro_top_properties i_props (.clk_sys, .rst_b, .bus_cs_n, .bus_req,
  .unlock_pulse, .hard_reset_pin_n, .reset_cfg_word, .bus_rsp, .ctl_out, .board_out,
  .cfg_drive);

//--- verification/bcro_host_model.sv
/* Host bus master model: one strobed access per go cycle.
   Assumes the bench raises go for one cycle per access. */
`timescale 1ns/1ns
module bcro_host_model import bcro_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        go,
  input  wire logic        go_cs_n,
  input  wire logic        go_wr,
  input  wire logic [4:0]  go_addr,
  input  wire logic [31:0] go_data,
  output logic             bus_cs_n,
  output bcro_bus_req_t    bus_req
);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_cs_n <= 1'b1;
      bus_req  <= '0;
    end else if (go) begin
      bus_cs_n <= go_cs_n;
      bus_req  <= '{1'b1, go_wr, go_addr, go_data};
    end else begin
      // Released bus floats: flip to the inverse each idle cycle, so stale values return only every second idle cycle
      bus_cs_n       <= 1'b1;
      bus_req.strobe <= 1'b0;
      bus_req.write  <= ~bus_req.write;
      bus_req.addr   <= ~bus_req.addr;
      bus_req.wdata  <= ~bus_req.wdata;
    end
  end
endmodule

//--- verification/bcro_top_tb_top.sv
/* Bench for bcro_top: access, lock, hiding, supply decode, hard reset.
   Assumes the host model drives the bus; bench drives unlock and reset pins. */
`timescale 1ns/1ns
module bcro_top_tb_top import bcro_pkg::*;;
  logic clk_sys = 0, rst_b = 0, go = 0, go_cs_n = 1, go_wr = 0, ok, bus_cs_n, cfg_drive;
  logic unlock_pulse = 0, hard_reset_pin_n = 1;
  logic [4:0] go_addr = '0;
  logic [31:0] go_data = '0, seed = 32'h79B3976B, rd, d;
  logic [15:0] reset_cfg_word = '0, e;
  bcro_bus_req_t bus_req;
  bcro_bus_rsp_t bus_rsp;
  bcro_ctl_t ctl_out;
  bcro_board_t board_out;
  int n_errors = 0, checked = 0, i;
  always #50 clk_sys = ~clk_sys;
  bcro_host_model i_host (.clk_sys, .rst_b, .go, .go_cs_n, .go_wr, .go_addr, .go_data,
    .bus_cs_n, .bus_req);
  bcro_top i_dut (.clk_sys, .rst_b, .bus_cs_n, .bus_req, .unlock_pulse, .hard_reset_pin_n,
    .reset_cfg_word, .bus_rsp, .ctl_out, .board_out, .cfg_drive);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Lock bit always falls on a write; bit 6 only moves while unlocked
  function automatic logic [15:0] nxt(input logic [15:0] c, input logic [15:0] w);
    return {w[15:7], (c[5] ? w[6] : c[6]), 1'b0, w[4:0]};
  endfunction
  function automatic bcro_vcc_t vcc_of(input logic [15:0] c);
    case ({c[9], c[15]})
      2'b01: return BCRO_VCC_5V;
      2'b10: return BCRO_VCC_3V3;
      default: return BCRO_VCC_0V;
    endcase
  endfunction
  function automatic bcro_vpp_t vpp_of(input logic [15:0] c);
    case ({c[10], c[11]})
      2'b00: return BCRO_VPP_0V;
      2'b01: return BCRO_VPP_5V;
      2'b10: return BCRO_VPP_12V;
      default: return BCRO_VPP_HIZ;
    endcase
  endfunction
  // Board enables as each control bit maps them, active high by name
  function automatic bcro_board_t brd(input logic [15:0] c);
    return '{~c[0], c[0], ~c[1], c[1], ~c[2], c[2], ~c[3], c[3], ~c[4], ~c[6], c[6],
             ~c[7], ~c[13], ~c[8], vcc_of(c), vpp_of(c), ~c[12], c[14], ~c[14]};
  endfunction
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task acc(input logic w, input logic cs, input logic [4:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    go <= 1'b1;
    go_wr <= w;
    go_cs_n <= cs;
    go_addr <= a;
    go_data <= v;
    @(posedge clk_sys);
    go <= 1'b0;
    ok = 1'b0;
    rd = '0;
    repeat (3) begin
      @(posedge clk_sys);
      #1;
      if (bus_rsp.ack === 1'b1) begin
        ok = 1'b1;
        rd = bus_rsp.rdata;
      end
    end
  endtask
  task wrr(input logic [31:0] v);
    acc(1'b1, 1'b0, 5'h04, v);
    chk("ack", 1, ok);
    e = nxt(e, v[15:0]);
    chk("ctl", e, ctl_out);
    chk("vcc", vcc_of(e), board_out.card_vcc);
    chk("vpp", vpp_of(e), board_out.card_vpp);
    chk("board", brd(e), board_out);
  endtask
  task unl;
    @(posedge clk_sys);
    unlock_pulse <= 1'b1;
    @(posedge clk_sys);
    unlock_pulse <= 1'b0;
    #1 e[5] = 1'b1;
    chk("ctl", e, ctl_out);
  endtask
  task hr(input logic dr);
    @(posedge clk_sys);
    reset_cfg_word <= seed[15:0];
    hard_reset_pin_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 chk("cfg", dr, cfg_drive);
    if (dr) chk("word", {16'h0000, reset_cfg_word}, bus_rsp.rdata);
    acc(1'b1, 1'b0, 5'h04, ~{16'h0000, e});
    chk("ack", 0, ok);
    chk("ctl", e, ctl_out);
    @(posedge clk_sys);
    hard_reset_pin_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 chk("cfg", 0, cfg_drive);
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    n_errors++;
    wrap_up();
  end
  initial begin
    e = 16'h7D1C;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1 chk("ctl", e, ctl_out);
    chk("board", BCRO_BOARD_RESET, board_out);
    acc(1'b0, 1'b0, 5'h04, '1);
    chk("rd", {16'h0000, e}, rd);
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
      acc(i[0], i == 5, (i == 5) ? 5'h04 : 5'(i * 4 + 1), '1);
      chk("ack", 0, ok);
      chk("ctl", e, ctl_out);
    end
    $display("decode test done");
    for (i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      d = seed;
      {d[11], d[10], d[15], d[9]} = 4'(i);
      wrr(d);
      acc(1'b0, 1'b0, 5'h04, seed);
      chk("rd", {16'h0000, e}, rd);
    end
    $display("random write test done");
    wrr(32'h0000_0010);
    hr(1'b1);
    wrr(32'h0000_0000);
    hr(1'b0);
    $display("hard reset test done");
    unl();
    wrr(32'h0000_0000);
    wrr(32'h0000_0040);
    unl();
    wrr(32'hFFFF_FFFF);
    chk("cs1", 1, board_out.cs1_offboard);
    acc(1'b0, 1'b0, 5'h04, '0);
    chk("ack", 0, ok);
    hr(1'b1);
    $display("hide test done");
    wrap_up();
  end
endmodule
